// File: dv/report_sink.sv
`timescale 1ns/1ps
// Root complex side: tallies error reports as they arrive
module report_sink (
	input  wire logic        clk,
	input  wire logic        clr_n,
	input  wire logic        pulse,
	input  wire logic [31:0] classes,
	output int               n_reports,
	output logic      [31:0] last
);
	always_ff @(posedge clk) begin
		if (!clr_n) begin
			n_reports <= 0;
			last <= 32'h00000000;
		end else if (pulse) begin
			n_reports <= n_reports + 1;
			last <= classes;
		end
	end
endmodule // report_sink

// File: dv/tb.sv
`timescale 1ns/1ps
module tb;
	logic        clk, rst_n, por_n, wr, rd, rv, rp;
	logic [11:0] addr;
	logic [3:0]  be;
	logic [31:0] wd, det, rdat, st, mk, rep, v, m, d, last;
	int          errors, n_compared, n_rep, exp_rep;

	uncorrectable_error_mask i_uncorrectable_error_mask (.SYS_CLK(clk),
		.RST_N(rst_n), .POR_N(por_n), .CFG_WR(wr), .CFG_RD(rd),
		.CFG_ADDR(addr), .CFG_WDATA(wd), .CFG_BE(be), .ERR_DETECT(det),
		.CFG_RDATA(rdat), .CFG_RVALID(rv), .STATUS_OUT(st), .MASK_OUT(mk),
		.REPORT_OUT(rep), .REPORT_PULSE(rp));
	report_sink i_report_sink (.clk(clk), .clr_n(por_n), .pulse(rp),
		.classes(rep), .n_reports(n_rep), .last(last));

	// ==========================================================
	// Helpers
	task automatic conclude;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		n_compared++;
		if (s !== x) begin
			errors++;
			$display("CHECK FAILED %0t seen %h exp %h", $time, s, x);
		end
	endtask
	task automatic step;
		@(posedge clk);
		#1;
	endtask
	// Extra idle cycle keeps the strobe from toggling twice in a step
	task automatic wreg(input logic [11:0] a, input logic [31:0] dd);
		addr = a;
		wd = dd;
		be = 4'hF;
		wr = 1'b1;
		step;
		wr = 1'b0;
		step;
	endtask
	task automatic rreg(input logic [11:0] a, output logic [31:0] q);
		addr = a;
		be = 4'hF;
		rd = 1'b1;
		step;
		rd = 1'b0;
		for (int i = 0; i < 4 && rv !== 1'b1; i++)
			step;
		if (rv !== 1'b1) begin
			errors++;
			conclude;
		end
		q = rdat;
		step;
	endtask
	function automatic logic [31:0] exp_rd(input logic [31:0] x);
		return x & uem_pkg::UEM_WMASK;
	endfunction
	function automatic logic [31:0] exp_r(input logic [31:0] mm, dd);
		return dd & ~(mm & uem_pkg::UEM_GATEMASK);
	endfunction

	// ==========================================================
	// Sequence
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#200000;
		errors++;
		conclude;
	end
	initial begin
		{rst_n, por_n, wr, rd, addr, be, wd, det} = '0;
		errors = 0;
		n_compared = 0;
		exp_rep = 0;
		void'($urandom(13618));
		repeat (3) step;
		rst_n = 1'b1;
		por_n = 1'b1;
		rreg(uem_pkg::UEM_OFFSET, v);
		chk(v, uem_pkg::UEM_RESET);
		for (int b = 0; b < 32; b++) begin
			wreg(uem_pkg::UEM_OFFSET, 32'h00000001 << b);
			rreg(uem_pkg::UEM_OFFSET, v);
			chk(v, exp_rd(32'h00000001 << b));
		end
		// Corner cases first: every bit set, every class detected
		for (int k = 0; k < 16; k++) begin
			m = (k == 0) ? 32'hFFFFFFFF : $urandom;
			wreg(uem_pkg::UEM_OFFSET, m);
			rreg(uem_pkg::UEM_OFFSET, v);
			chk(v, exp_rd(m));
			chk(mk, m & uem_pkg::UEM_GATEMASK);
			wreg(uem_pkg::UES_OFFSET, 32'hFFFFFFFF);
			d = (k < 2) ? uem_pkg::UES_SETMASK : $urandom;
			d = d & uem_pkg::UES_SETMASK;
			det = d;
			step;
			det = 32'h00000000;
			chk(rep, exp_r(m, d));
			chk(st, exp_r(m, d));
			if (exp_r(m, d) != 32'h00000000)
				exp_rep++;
			rreg(uem_pkg::UES_OFFSET, v);
			chk(v, exp_r(m, d));
			if (exp_r(m, d) != 32'h00000000)
				chk(last, exp_r(m, d));
		end
		chk(32'(n_rep), 32'(exp_rep));
		rreg(12'h200, v);
		chk(v, 32'h00000000);
		rst_n = 1'b0;
		repeat (3) step;
		rst_n = 1'b1;
		rreg(uem_pkg::UEM_OFFSET, v);
		chk(v, exp_rd(m));
		por_n = 1'b0;
		repeat (3) step;
		por_n = 1'b1;
		rreg(uem_pkg::UEM_OFFSET, v);
		chk(v, uem_pkg::UEM_RESET);
		conclude;
	end
endmodule // tb

// File: hw/sticky_bit.sv
`timescale 1ns/1ps
// One sticky register bit: reset to RESET_VAL only by power-on reset, otherwise changed only by a write
module sticky_bit #(
	parameter bit RESET_VAL = 1'b0
) (
	input  wire logic clk,
	input  wire logic por_n,
	input  wire logic wr_en,
	input  wire logic wr_val,
	output logic      q
);
	always_ff @(posedge clk) begin
		if (!por_n) begin
			q <= RESET_VAL;
		end else if (wr_en) begin
			q <= wr_val;
		end
	end
endmodule // sticky_bit

// File: hw/uncorrectable_error_mask.sv
`timescale 1ns/1ps
module uncorrectable_error_mask (
	input  wire logic        SYS_CLK,
	input  wire logic        RST_N,
	input  wire logic        POR_N,
	input  wire logic        CFG_WR,
	input  wire logic        CFG_RD,
	input  wire logic [11:0] CFG_ADDR,
	input  wire logic [31:0] CFG_WDATA,
	input  wire logic [3:0]  CFG_BE,
	input  wire logic [31:0] ERR_DETECT,
	output logic      [31:0] CFG_RDATA,
	output logic             CFG_RVALID,
	output logic      [31:0] STATUS_OUT,
	output logic      [31:0] MASK_OUT,
	output logic      [31:0] REPORT_OUT,
	output logic             REPORT_PULSE
);
	// ==========================================================
	// Decode
	logic [31:0] be_bits;
	logic        hit_mask;
	logic        hit_status;
	logic [31:0] mask_q;
	logic [31:0] mask_wen;
	logic [31:0] status_r;
	logic [31:0] status_nxt;
	logic [31:0] gated_detect;

	always_comb begin
		be_bits = {{8{CFG_BE[3]}}, {8{CFG_BE[2]}},
			{8{CFG_BE[1]}}, {8{CFG_BE[0]}}};
	end
	assign hit_mask   = CFG_ADDR == uem_pkg::UEM_OFFSET;
	assign hit_status = CFG_ADDR == uem_pkg::UES_OFFSET;

	// ==========================================================
	// Mask bits: only writable positions get storage
	// Reserved and hardwired bits have no flop, so writes vanish
	assign mask_wen = (CFG_WR && hit_mask) ?
		(be_bits & uem_pkg::UEM_WMASK) : 32'h00000000;

	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_mask
			if (uem_pkg::UEM_WMASK[gi]) begin : g_rw
				// Warm reset RST_N deliberately not used here
				sticky_bit #(
					.RESET_VAL (uem_pkg::UEM_RESET[gi])
				) u_bit (
					.clk    (SYS_CLK),
					.por_n  (POR_N),
					.wr_en  (mask_wen[gi]),
					.wr_val (CFG_WDATA[gi]),
					.q      (mask_q[gi])
				);
			end else begin : g_ro
				assign mask_q[gi] = 1'b0;
			end
		end
	endgenerate

	// ==========================================================
	// Status logging, gated by mask
	// Obsolete bit 0 is not in the gate set, so it never masks
	assign gated_detect = ERR_DETECT & uem_pkg::UES_SETMASK &
		~(mask_q & uem_pkg::UEM_GATEMASK);

	always_comb begin
		status_nxt = status_r;
		if (CFG_WR && hit_status) begin
			status_nxt = status_nxt & ~(CFG_WDATA & be_bits);
		end
		// Set wins over a clear in the same cycle
		status_nxt = status_nxt | gated_detect;
	end

	// Status is sticky as well: power-on only
	always_ff @(posedge SYS_CLK) begin
		if (!POR_N) begin
			status_r <= uem_pkg::UES_RESET;
		end else begin
			status_r <= status_nxt;
		end
	end

	// ==========================================================
	// Reporting toward the root complex
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			REPORT_OUT   <= 32'h00000000;
			REPORT_PULSE <= 1'b0;
		end else begin
			REPORT_OUT   <= gated_detect;
			REPORT_PULSE <= |gated_detect;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			STATUS_OUT <= 32'h00000000;
			MASK_OUT   <= 32'h00000000;
		end else begin
			STATUS_OUT <= status_nxt;
			MASK_OUT   <= mask_q & uem_pkg::UEM_GATEMASK;
		end
	end

	// ==========================================================
	// Read port: one cycle latency, unmapped reads zero
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			CFG_RDATA  <= 32'h00000000;
			CFG_RVALID <= 1'b0;
		end else begin
			CFG_RVALID <= CFG_RD;
			if (CFG_RD && hit_mask) begin
				CFG_RDATA <= mask_q & be_bits;
			end else if (CFG_RD && hit_status) begin
				CFG_RDATA <= status_r & be_bits;
			end else begin
				CFG_RDATA <= 32'h00000000;
			end
		end
	end

	// ==========================================================
	// Checks
	a_masked_no_report: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		(ERR_DETECT[uem_pkg::UNSUP_POS] && mask_q[uem_pkg::UNSUP_POS])
		|=> !REPORT_OUT[uem_pkg::UNSUP_POS])
		else $error("masked error reported");
	// Covers every gated class at once, not just one sample bit
	a_masked_none_out: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		RST_N |=> (REPORT_OUT & $past(mask_q) &
			uem_pkg::UEM_GATEMASK) == 32'h00000000)
		else $error("masked class reached report");
	a_masked_no_log: assert property (@(posedge SYS_CLK)
		disable iff (!POR_N)
		(!status_r[uem_pkg::LINK_PROT_POS] &&
		 mask_q[uem_pkg::LINK_PROT_POS] &&
		 !(CFG_WR && hit_mask))
		|=> !status_r[uem_pkg::LINK_PROT_POS])
		else $error("masked error logged");
	a_unmasked_logs: assert property (@(posedge SYS_CLK)
		disable iff (!POR_N)
		(ERR_DETECT[uem_pkg::SURPRISE_POS] &&
		 !mask_q[uem_pkg::SURPRISE_POS])
		|=> status_r[uem_pkg::SURPRISE_POS])
		else $error("unmasked error not logged");
	a_mask_write_takes: assert property (@(posedge SYS_CLK)
		disable iff (!POR_N)
		(CFG_WR && hit_mask && CFG_BE[1])
		|=> mask_q[uem_pkg::POISONED_POS] ==
			$past(CFG_WDATA[uem_pkg::POISONED_POS]) &&
			mask_q[uem_pkg::FLOW_CTRL_POS] ==
			$past(CFG_WDATA[uem_pkg::FLOW_CTRL_POS]))
		else $error("mask write lost");
	a_hardwired_zero: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		CFG_RVALID && $past(hit_mask) |->
		CFG_RDATA[uem_pkg::COMP_AB_POS:uem_pkg::COMP_TO_POS] == 2'b00)
		else $error("hardwired bit reads one");
	a_mask_readback: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		(CFG_RD && hit_mask && CFG_BE[2])
		|=> CFG_RDATA[uem_pkg::ECRC_POS:uem_pkg::UNEXP_POS] ==
			$past(mask_q[uem_pkg::ECRC_POS:uem_pkg::UNEXP_POS]))
		else $error("mask bits read back wrong");
	a_unsup_no_log: assert property (@(posedge SYS_CLK)
		disable iff (!POR_N)
		(ERR_DETECT[uem_pkg::UNSUP_POS] && mask_q[uem_pkg::UNSUP_POS] &&
		 !status_r[uem_pkg::UNSUP_POS])
		|=> !status_r[uem_pkg::UNSUP_POS])
		else $error("masked request error logged");
	a_reserved_zero: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		CFG_RVALID |-> (CFG_RDATA & ~uem_pkg::UEM_WMASK &
			~uem_pkg::UES_SETMASK) == 32'h00000000)
		else $error("reserved bit reads one");
	a_sticky_warm: assert property (@(posedge SYS_CLK)
		POR_N && !RST_N && !CFG_WR |=> $stable(mask_q))
		else $error("mask lost on warm reset");
	// Obsolete bit set must still let its event be logged
	a_obsolete_log: assert property (@(posedge SYS_CLK)
		disable iff (!POR_N)
		(ERR_DETECT[uem_pkg::OBSOLETE_POS] &&
		 mask_q[uem_pkg::OBSOLETE_POS])
		|=> status_r[uem_pkg::OBSOLETE_POS])
		else $error("obsolete bit gated logging");
	a_obsolete_report: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		ERR_DETECT[uem_pkg::OBSOLETE_POS] |=>
		REPORT_OUT[uem_pkg::OBSOLETE_POS])
		else $error("obsolete bit masked an event");
	a_gate_out_match: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		RST_N |=> MASK_OUT == ($past(mask_q) & uem_pkg::UEM_GATEMASK))
		else $error("gating mask output wrong");
	a_w1c_clear: assert property (@(posedge SYS_CLK)
		disable iff (!POR_N)
		(CFG_WR && hit_status && CFG_BE[2] &&
		 CFG_WDATA[uem_pkg::RX_OVF_POS] &&
		 !ERR_DETECT[uem_pkg::RX_OVF_POS])
		|=> !status_r[uem_pkg::RX_OVF_POS])
		else $error("write one did not clear");
	// Same-cycle event and clear: the event must survive
	a_set_wins: assert property (@(posedge SYS_CLK)
		disable iff (!POR_N)
		(CFG_WR && hit_status && CFG_BE[0] &&
		 CFG_WDATA[uem_pkg::LINK_PROT_POS] &&
		 ERR_DETECT[uem_pkg::LINK_PROT_POS] &&
		 !mask_q[uem_pkg::LINK_PROT_POS])
		|=> status_r[uem_pkg::LINK_PROT_POS])
		else $error("clear beat a new event");
	a_read_timing: assert property (@(posedge SYS_CLK)
		disable iff (!RST_N)
		CFG_RD |=> CFG_RVALID)
		else $error("read answer late");
	a_warm_quiet: assert property (@(posedge SYS_CLK)
		!RST_N |=> REPORT_OUT == 32'h00000000 && !REPORT_PULSE &&
			!CFG_RVALID)
		else $error("output active in warm reset");
endmodule // uncorrectable_error_mask

// File: shared/uem_pkg.sv
package uem_pkg;
	// ==========================================================
	// Register map
	localparam logic [11:0] UEM_OFFSET    = 12'h108;
	localparam logic [11:0] UES_OFFSET    = 12'h104;
	localparam logic [31:0] UEM_RESET     = 32'h00000000;
	localparam logic [31:0] UES_RESET     = 32'h00000000;
	// ==========================================================
	// Field positions
	localparam int OBSOLETE_POS  = 0;
	localparam int LINK_PROT_POS = 4;
	localparam int SURPRISE_POS  = 5;
	localparam int POISONED_POS  = 12;
	localparam int FLOW_CTRL_POS = 13;
	localparam int COMP_TO_POS   = 14;
	localparam int COMP_AB_POS   = 15;
	localparam int UNEXP_POS     = 16;
	localparam int RX_OVF_POS    = 17;
	localparam int MALFORMED_POS = 18;
	localparam int ECRC_POS      = 19;
	localparam int UNSUP_POS     = 20;
	// Writable bits of the mask (obsolete bit plus the mask bits)
	localparam logic [31:0] UEM_WMASK     = 32'h001F3031;
	// Bits that gate logging and reporting
	localparam logic [31:0] UEM_GATEMASK  = 32'h001F3030;
	// Status bits that hardware may set
	localparam logic [31:0] UES_SETMASK   = 32'h001F3031;
	// ==========================================================
	// Access state
	typedef enum logic [1:0] {
		ACC_IDLE  = 2'b00,
		ACC_READ  = 2'b01,
		ACC_WRITE = 2'b11
	} acc_state_type;
endpackage
